//--- logic/imc_regs.vh
// register map, field positions, reset values and phase codes of the
// two-wire bus master controller; included by the baud generator and master design files
`ifndef IMC_REGS_VH
`define IMC_REGS_VH

// ==========================================================================
// register addresses
`define IMC_ADDR_DATA 3'h0
`define IMC_ADDR_STATUS 3'h1
`define IMC_ADDR_CONTROL 3'h2
`define IMC_ADDR_BAUD_HI 3'h3
`define IMC_ADDR_BAUD_LO 3'h4
`define IMC_ADDR_DIAG 3'h5

// ==========================================================================
// control register fields
`define IMC_CTL_ENABLE 7
`define IMC_CTL_START 6
`define IMC_CTL_STOP 5
`define IMC_CTL_BAUD_IRQ 4
`define IMC_CTL_TX_IRQ 3
`define IMC_CTL_NAK 2
`define IMC_CTL_FLUSH 1

// ==========================================================================
// status register fields
`define IMC_ST_TX_EMPTY 7
`define IMC_ST_RX_FULL 6
`define IMC_ST_ACK 5
`define IMC_ST_TEN_BIT 4
`define IMC_ST_READ 3
`define IMC_ST_BUSY 2
`define IMC_ST_NACK 1

// ==========================================================================
// reset values and constants
`define IMC_BAUD_RESET 16'hFFFF
`define IMC_BYTE_ZERO 8'h00
`define IMC_BIT_FIRST 3'h7
`define IMC_BIT_LAST 3'h0
`define IMC_TEN_BIT_TAG 5'h1E
`define IMC_MAX_RATE_KBPS 400

// ==========================================================================
// quarter phases of one bus clock period
`define IMC_Q_LOW 2'h0
`define IMC_Q_MIDLOW 2'h1
`define IMC_Q_RISE 2'h2
`define IMC_Q_MIDHIGH 2'h3

`endif

//--- logic/imc_sync2.v
// two-stage synchroniser for the bus pin levels
// assumes the inputs are asynchronous to mclk
`timescale 1ns/1ps
module imc_sync2 #(
	parameter WIDTH = 2
) (
	input wire mclk, // system clock
	input wire reset_n, // synchronous reset, active low
	input wire [WIDTH-1:0] async, // raw pin levels
	output reg [WIDTH-1:0] synced // levels safe to use in mclk domain
);
	reg [WIDTH-1:0] meta;

	// released bus lines idle high, so both stages reset to one
	always @(posedge mclk) begin
		if (!reset_n) begin
			meta <= {WIDTH{1'b1}};
			synced <= {WIDTH{1'b1}};
		end else begin
			meta <= async;
			synced <= meta;
		end
	end
endmodule // imc_sync2

//--- logic/imc_baud_gen.v
// reloadable down-counter: bus quarter-phase ticks and general timer
// assumes reload and load come from logic on mclk
`timescale 1ns/1ps
`include "imc_regs.vh"
module imc_baud_gen #(
	parameter WIDTH = 16
) (
	input wire mclk, // system clock
	input wire reset_n, // synchronous reset, active low
	input wire run, // counter runs while high
	input wire load, // restart from the reload value
	input wire [WIDTH-1:0] reload, // reload value
	output reg tick, // one-cycle pulse each time the count reaches one
	output reg [WIDTH-1:0] count // current count
);
	wire atOne;

	assign atOne = (count <= {{(WIDTH-1){1'b0}}, 1'b1});

	always @(posedge mclk) begin
		if (!reset_n) begin
			count <= `IMC_BAUD_RESET;
			tick <= 1'b0;
		end else if (!run || load) begin
			count <= reload;
			tick <= 1'b0;
		end else if (atOne) begin
			count <= reload;
			tick <= 1'b1;
		end else begin
			count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
			tick <= 1'b0;
		end
	end
endmodule // imc_baud_gen

//--- logic/imc_master.v
// two-wire serial bus master controller: registers, bit engine, flags
// assumes a plain register port on mclk and open-drain pads outside
//
// Behaviour
// - master only, transmit and receive; no slave mode, no arbitration
// - bus rates up to 400 kbit/s
// - master transmit and receive with 7-bit or 10-bit addresses
// - bytes and acknowledges go MSB first; unlimited bytes per transfer
// - pins become open-drain outputs when alternate function selected
// - slave may stretch clock low; master waits until it is released
// - data changes mid clock low, sampled mid clock high
// - transmit, receive, nack and timer sources merge onto one irq
// - tx irq needs enable and tx enable; rx, nack need enable
// - nack without start or stop sets flag and halts until either set
// - receive full set in ack phase; stall until data register read
// - transmit empty sets on enable and on first bit of sent bytes, not of read addresses
// - writing the data register clears transmit empty
// - transmit empty stalls the byte at the start of its ack clock
// - no stall before ack when start or stop already set
// - disabled with timer select: irq each time baud count reaches one
// - transmit empty independent of tx enable; tx DMA needs tx enable
// - start is data low with clock high; stop is data rising
// - start only after start bit and data written; start at end restarts
// - flush with start or stop discards stale transmit byte
// - start and stop together: stop cleared at end, no nack irq
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "imc_regs.vh"
module imc_master #(
	parameter BAUD_WIDTH = 16
) (
	input wire mclk, // system clock, 25 MHz
	input wire reset_n, // synchronous reset, active low
	input wire [2:0] addr, // register address
	input wire [7:0] wrData, // register write data
	input wire wrStb, // register write strobe
	input wire rdStb, // register read strobe
	output reg [7:0] rdData, // read data, valid the cycle after rdStb
	input wire altFuncSel, // pins routed to this controller
	input wire sclIn, // clock line level
	input wire sdaIn, // data line level
	output reg sclOut, // clock line drive value, always low
	output reg sclOe, // pull clock line low
	output reg sdaOut, // data line drive value, always low
	output reg sdaOe, // pull data line low
	output reg irq, // merged interrupt request
	output reg dmaTxReq, // transmit DMA request
	output reg dmaRxReq // receive DMA request
);
	// ======================================================================
	// states
	localparam ST_IDLE = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_BYTE = 3'h2;
	localparam ST_ACK = 3'h3;
	localparam ST_NEXT = 3'h4;
	localparam ST_WAIT = 3'h5;
	localparam ST_STOP = 3'h6;

	// ======================================================================
	// registers and engine state
	reg enable;
	reg startBit;
	reg stopBit;
	reg baudTimerIrqSelect;
	reg transmitIrqEnable;
	reg nakBit;
	reg transmitEmptyFlag;
	reg receiveFullFlag;
	reg nackIrqFlag;
	reg ackSeen;
	reg [7:0] txData;
	reg [7:0] rxData;
	reg [BAUD_WIDTH-1:0] baudReload;
	reg baudLoad;
	reg [2:0] state;
	reg [1:0] phase;
	reg [2:0] bitCnt;
	reg [7:0] shiftReg;
	reg isAddr;
	reg reading;
	reg tenBit;
	reg nackEv;
	reg sclLow;
	reg sdaLow;
	reg [7:0] next_rdData;

	wire tick;
	wire [BAUD_WIDTH-1:0] baudCount;
	wire [1:0] pinSync;
	wire sclS;
	wire sdaS;
	wire txByte;
	wire wrCtl;
	wire endReq;

	assign sclS = pinSync[1];
	assign sdaS = pinSync[0];
	assign txByte = isAddr | ~reading;
	assign wrCtl = wrStb && (addr == `IMC_ADDR_CONTROL);
	assign endReq = startBit | stopBit;

	// ======================================================================
	// submodules
	imc_sync2 #(
		.WIDTH(2)
	) uSync (
		.mclk(mclk),
		.reset_n(reset_n),
		.async({sclIn, sdaIn}),
		.synced(pinSync)
	);

	imc_baud_gen #(
		.WIDTH(BAUD_WIDTH)
	) uBaud (
		.mclk(mclk),
		.reset_n(reset_n),
		.run(enable | baudTimerIrqSelect),
		.load(baudLoad),
		.reload(baudReload),
		.tick(tick),
		.count(baudCount)
	);

	// ======================================================================
	// read mux
	always @* begin
		next_rdData = `IMC_BYTE_ZERO;
		case (addr)
			`IMC_ADDR_DATA: next_rdData = rxData;
			`IMC_ADDR_STATUS: begin
				next_rdData[`IMC_ST_TX_EMPTY] = transmitEmptyFlag;
				next_rdData[`IMC_ST_RX_FULL] = receiveFullFlag;
				next_rdData[`IMC_ST_ACK] = ackSeen;
				next_rdData[`IMC_ST_TEN_BIT] = tenBit;
				next_rdData[`IMC_ST_READ] = reading;
				next_rdData[`IMC_ST_BUSY] = (state != ST_IDLE);
				next_rdData[`IMC_ST_NACK] = nackIrqFlag;
			end
			`IMC_ADDR_CONTROL: begin
				next_rdData[`IMC_CTL_ENABLE] = enable;
				next_rdData[`IMC_CTL_START] = startBit;
				next_rdData[`IMC_CTL_STOP] = stopBit;
				next_rdData[`IMC_CTL_BAUD_IRQ] = baudTimerIrqSelect;
				next_rdData[`IMC_CTL_TX_IRQ] = transmitIrqEnable;
				next_rdData[`IMC_CTL_NAK] = nakBit;
			end
			`IMC_ADDR_BAUD_HI: next_rdData = baudReload[15:8];
			`IMC_ADDR_BAUD_LO: next_rdData = baudReload[7:0];
			`IMC_ADDR_DIAG: next_rdData = {state, phase, bitCnt};
			default: next_rdData = `IMC_BYTE_ZERO;
		endcase
	end

	// ======================================================================
	// register file, flags and bit engine
	always @(posedge mclk) begin
		if (!reset_n) begin
			rdData <= `IMC_BYTE_ZERO;
			enable <= 1'b0;
			startBit <= 1'b0;
			stopBit <= 1'b0;
			baudTimerIrqSelect <= 1'b0;
			transmitIrqEnable <= 1'b0;
			nakBit <= 1'b0;
			transmitEmptyFlag <= 1'b1;
			receiveFullFlag <= 1'b0;
			nackIrqFlag <= 1'b0;
			ackSeen <= 1'b0;
			txData <= `IMC_BYTE_ZERO;
			rxData <= `IMC_BYTE_ZERO;
			baudReload <= `IMC_BAUD_RESET;
			baudLoad <= 1'b0;
			state <= ST_IDLE;
			phase <= `IMC_Q_LOW;
			bitCnt <= `IMC_BIT_FIRST;
			shiftReg <= `IMC_BYTE_ZERO;
			isAddr <= 1'b0;
			reading <= 1'b0;
			tenBit <= 1'b0;
			nackEv <= 1'b0;
			sclLow <= 1'b0;
			sdaLow <= 1'b0;
		end else begin
			rdData <= rdStb ? next_rdData : `IMC_BYTE_ZERO;
			baudLoad <= 1'b0;

			// software side: clears first so hardware sets below win
			if (rdStb && (addr == `IMC_ADDR_DATA))
				receiveFullFlag <= 1'b0;
			if (wrStb && (addr == `IMC_ADDR_DATA)) begin
				txData <= wrData;
				transmitEmptyFlag <= 1'b0;
			end
			if (wrStb && (addr == `IMC_ADDR_BAUD_HI)) begin
				baudReload[15:8] <= wrData;
				baudLoad <= 1'b1;
			end
			if (wrStb && (addr == `IMC_ADDR_BAUD_LO)) begin
				baudReload[7:0] <= wrData;
				baudLoad <= 1'b1;
			end

			// bus engine, quarter phases paced by the baud ticks
			case (state)
				ST_IDLE: begin
					sclLow <= 1'b0;
					sdaLow <= 1'b0;
					if (enable && startBit && !transmitEmptyFlag) begin
						state <= ST_START;
						phase <= `IMC_Q_MIDLOW;
					end
				end
				ST_START: if (tick) begin
					case (phase)
						`IMC_Q_LOW: begin
							sclLow <= 1'b1;
							phase <= `IMC_Q_MIDLOW;
						end
						`IMC_Q_MIDLOW: begin
							sdaLow <= 1'b0;
							phase <= `IMC_Q_RISE;
						end
						`IMC_Q_RISE: begin
							sclLow <= 1'b0;
							phase <= `IMC_Q_MIDHIGH;
						end
						default: if (sclS) begin
							sdaLow <= 1'b1;
							startBit <= 1'b0;
							shiftReg <= txData;
							reading <= txData[0];
							tenBit <= (txData[7:3] == `IMC_TEN_BIT_TAG);
							isAddr <= 1'b1;
							bitCnt <= `IMC_BIT_FIRST;
							state <= ST_BYTE;
							phase <= `IMC_Q_LOW;
						end
					endcase
				end
				ST_BYTE: if (tick) begin
					case (phase)
						`IMC_Q_LOW: begin
							sclLow <= 1'b1;
							phase <= `IMC_Q_MIDLOW;
						end
						`IMC_Q_MIDLOW: begin
							sdaLow <= txByte & ~shiftReg[7];
							if (bitCnt == `IMC_BIT_FIRST && !reading)
								transmitEmptyFlag <= 1'b1;
							phase <= `IMC_Q_RISE;
						end
						`IMC_Q_RISE: begin
							sclLow <= 1'b0;
							phase <= `IMC_Q_MIDHIGH;
						end
						default: if (sclS) begin
							shiftReg <= {shiftReg[6:0], sdaS};
							bitCnt <= bitCnt - 3'h1;
							phase <= `IMC_Q_LOW;
							if (bitCnt == `IMC_BIT_LAST)
								state <= ST_ACK;
						end
					endcase
				end
				ST_ACK: if (tick) begin
					case (phase)
						`IMC_Q_LOW: begin
							sclLow <= 1'b1;
							phase <= `IMC_Q_MIDLOW;
						end
						`IMC_Q_MIDLOW: begin
							if (!txByte) begin
								rxData <= shiftReg;
								receiveFullFlag <= 1'b1;
								sdaLow <= ~nakBit;
								phase <= `IMC_Q_RISE;
							end else if (!transmitEmptyFlag || endReq) begin
								sdaLow <= 1'b0;
								phase <= `IMC_Q_RISE;
							end
						end
						`IMC_Q_RISE: begin
							sclLow <= 1'b0;
							phase <= `IMC_Q_MIDHIGH;
						end
						default: if (sclS) begin
							nackEv <= txByte ? sdaS : nakBit;
							if (txByte)
								ackSeen <= ~sdaS;
							isAddr <= 1'b0;
							phase <= `IMC_Q_LOW;
							state <= ST_NEXT;
						end
					endcase
				end
				ST_NEXT: begin
					if (nackEv && !endReq) begin
						nackIrqFlag <= 1'b1;
						state <= ST_WAIT;
					end else if (!(reading && receiveFullFlag)) begin
						nackEv <= 1'b0;
						if (stopBit) begin
							state <= ST_STOP;
						end else if (startBit) begin
							if (!transmitEmptyFlag)
								state <= ST_START;
						end else if (reading) begin
							bitCnt <= `IMC_BIT_FIRST;
							state <= ST_BYTE;
						end else if (!transmitEmptyFlag) begin
							shiftReg <= txData;
							bitCnt <= `IMC_BIT_FIRST;
							state <= ST_BYTE;
						end
					end
				end
				ST_WAIT: begin
					if (endReq) begin
						nackEv <= 1'b0;
						state <= ST_NEXT;
					end
				end
				ST_STOP: if (tick) begin
					case (phase)
						`IMC_Q_LOW: begin
							sclLow <= 1'b1;
							phase <= `IMC_Q_MIDLOW;
						end
						`IMC_Q_MIDLOW: begin
							sdaLow <= 1'b1;
							phase <= `IMC_Q_RISE;
						end
						`IMC_Q_RISE: begin
							sclLow <= 1'b0;
							phase <= `IMC_Q_MIDHIGH;
						end
						default: if (sclS) begin
							sdaLow <= 1'b0;
							stopBit <= 1'b0;
							reading <= 1'b0;
							phase <= `IMC_Q_LOW;
							state <= ST_IDLE;
						end
					endcase
				end
				default: state <= ST_IDLE;
			endcase

			// control writes after the engine: a software set wins over the engine clearing
			if (wrCtl) begin
				enable <= wrData[`IMC_CTL_ENABLE];
				baudTimerIrqSelect <= wrData[`IMC_CTL_BAUD_IRQ];
				transmitIrqEnable <= wrData[`IMC_CTL_TX_IRQ];
				nakBit <= wrData[`IMC_CTL_NAK];
				if (wrData[`IMC_CTL_START])
					startBit <= 1'b1;
				if (wrData[`IMC_CTL_STOP])
					stopBit <= 1'b1;
				if (wrData[`IMC_CTL_START] || wrData[`IMC_CTL_STOP]) begin
					nackIrqFlag <= 1'b0;
					if (wrData[`IMC_CTL_FLUSH])
						transmitEmptyFlag <= 1'b1;
				end
			end

			// disabled: engine parked, transmit empty set, receive full and nack flags cleared
			if (!enable) begin
				state <= ST_IDLE;
				phase <= `IMC_Q_LOW;
				sclLow <= 1'b0;
				sdaLow <= 1'b0;
				transmitEmptyFlag <= 1'b1;
				receiveFullFlag <= 1'b0;
				nackIrqFlag <= 1'b0;
			end
		end
	end

	// ======================================================================
	// pins, interrupt and DMA requests
	always @(posedge mclk) begin
		if (!reset_n) begin
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
			sclOe <= 1'b0;
			sdaOe <= 1'b0;
			irq <= 1'b0;
			dmaTxReq <= 1'b0;
			dmaRxReq <= 1'b0;
		end else begin
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
			sclOe <= altFuncSel & sclLow;
			sdaOe <= altFuncSel & sdaLow;
			irq <= (enable & ((transmitIrqEnable & transmitEmptyFlag) | receiveFullFlag
				| nackIrqFlag)) | (~enable & baudTimerIrqSelect & tick);
			dmaTxReq <= enable & transmitIrqEnable & transmitEmptyFlag;
			dmaRxReq <= enable & receiveFullFlag;
		end
	end
endmodule // imc_master

//--- verif/imc_master_props.sv
// assertions on the ports of the two-wire bus master controller
// assumes one clock domain, reset synchronous and active low
`timescale 1ns/1ps
`include "imc_regs.vh"
module imc_master_props (
	input wire mclk, // system clock
	input wire reset_n, // reset, active low
	input wire [2:0] addr, // register address
	input wire [7:0] wrData, // write data
	input wire wrStb, // write strobe
	input wire rdStb, // read strobe
	input wire [7:0] rdData, // read data
	input wire altFuncSel, // pins routed
	input wire sclIn, // clock line level
	input wire sdaIn, // data line level
	input wire sclOut, // clock drive value
	input wire sclOe, // clock pull enable
	input wire sdaOut, // data drive value
	input wire sdaOe, // data pull enable
	input wire irq, // merged interrupt
	input wire dmaTxReq, // transmit request
	input wire dmaRxReq // receive request
);
	reg ctlEn;
	reg ctlTxi;
	reg ctlTmr;
	// ==========================================================
	// shadow of the control bits
	always @(posedge mclk) begin
		if (!reset_n) begin
			{ctlEn, ctlTxi, ctlTmr} <= 3'h0;
		end else if (wrStb && addr == `IMC_ADDR_CONTROL) begin
			ctlEn <= wrData[`IMC_CTL_ENABLE];
			ctlTxi <= wrData[`IMC_CTL_TX_IRQ];
			ctlTmr <= wrData[`IMC_CTL_BAUD_IRQ];
		end
	end
	// ==========================================================
	// properties
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	AST_OE_GATED: assert property (!altFuncSel |=> !sclOe && !sdaOe)
		else $error("pin pulled while not routed");
	AST_DRIVE_LOW: assert property (!sclOut && !sdaOut)
		else $error("pin drives high");
	AST_TXDMA_GATE: assert property (dmaTxReq |-> ctlEn && ctlTxi || $past(ctlEn && ctlTxi))
		else $error("tx request without tx enable");
	AST_RXDMA_GATE: assert property (dmaRxReq |-> ctlEn || $past(ctlEn))
		else $error("rx request while disabled");
	AST_STRETCH_WAIT: assert property (!sclOe && !sclIn |=> !sclOe)
		else $error("clock driven during stretch");
	AST_DATA_MIDLOW: assert property ($changed(sdaOe) |-> $stable(sclOe))
		else $error("data moved with clock edge");
	AST_START_SCL_HIGH: assert property ($rose(sdaOe) && !sclOe |-> sclIn && $past(sclIn))
		else $error("start without clock high");
	AST_STOP_SCL_HIGH: assert property ($fell(sdaOe) && !sclOe |-> sclIn)
		else $error("stop without clock high");
	AST_TIMER_PULSE: assert property (ctlTmr && !ctlEn && irq |=> !irq)
		else $error("timer irq longer than one cycle");
	AST_IRQ_GATED: assert property (!ctlEn && !ctlTmr && $past(!ctlEn && !ctlTmr) |-> !irq)
		else $error("irq while disabled");
	cover property (!sclOe && !sclIn ##1 sclIn);
	cover property ($rose(dmaRxReq));
	cover property (ctlTmr && irq);
endmodule // imc_master_props

//--- verif/imc_slave_model.sv
// behavioural slave on the two-wire bus: acks, returns a byte, stretches
// assumes resolved line levels with pull-ups, sampled on mclk
`timescale 1ns/1ps
module imc_slave_model (
	input wire mclk, // system clock
	input wire scl, // resolved clock line
	input wire sda, // resolved data line
	input wire ackEn, // acknowledge written bytes
	input wire stretchEn, // hold clock low after each fall
	input wire [7:0] txByte, // byte returned on reads
	output reg sdaPull, // pull data line low
	output reg sclPull, // pull clock line low
	output reg [7:0] rxByte // last byte received
);
	reg sclQ = 1'b1;
	reg sdaQ = 1'b1;
	reg active = 1'b0;
	reg first = 1'b0;
	reg reading = 1'b0;
	reg mNack = 1'b0;
	reg [3:0] cnt = 4'h0;
	reg [4:0] hold = 5'h00;
	reg [7:0] sh = 8'h00;
	initial {sdaPull, sclPull, rxByte} = 10'h000;
	always @(posedge mclk) begin
		sclQ <= scl;
		sdaQ <= sda;
		if (hold != 5'h00) hold <= hold - 5'h01;
		else sclPull <= 1'b0;
		if (scl && sclQ && sdaQ && !sda) begin
			{active, first, reading, sdaPull} <= 4'hc;
			cnt <= 4'h0;
		end else if (scl && sclQ && !sdaQ && sda) begin
			{active, sdaPull} <= 2'h0;
		end else if (active && scl && !sclQ) begin
			// byte commits on its eighth bit: a stop's clock rise must not shift in
			if (cnt < 4'h8 && !reading) sh <= {sh[6:0], sda};
			if (cnt == 4'h7 && !reading) rxByte <= {sh[6:0], sda};
			if (cnt == 4'h8 && reading) mNack <= sda;
			cnt <= cnt + 4'h1;
		end else if (active && !scl && sclQ) begin
			if (stretchEn) begin
				sclPull <= 1'b1;
				hold <= 5'h0c;
			end
			if (cnt == 4'h8) begin
				sdaPull <= !reading && ackEn;
			end else if (cnt == 4'h9) begin
				cnt <= 4'h0;
				first <= 1'b0;
				if (first) reading <= rxByte[0];
				sdaPull <= (first ? rxByte[0] : reading && !mNack) && !txByte[7];
			end else if (reading) begin
				sdaPull <= !txByte[3'h7 - cnt[2:0]];
			end
		end
	end
endmodule // imc_slave_model

//--- verif/imc_master_tb.sv
// self-checking testbench of the two-wire bus master controller
// assumes the design, slave model and checker are compiled first
`timescale 1ns/1ps
`include "imc_regs.vh"
module imc_master_tb;
	reg mclk = 1'b0;
	reg reset_n = 1'b0;
	reg [2:0] addr = 3'h0;
	reg [7:0] wrData = 8'h00;
	reg wrStb = 1'b0;
	reg rdStb = 1'b0;
	reg altFuncSel = 1'b1;
	reg ackEn = 1'b1;
	reg stretchEn = 1'b0;
	reg [7:0] st;
	reg [7:0] n;
	wire [7:0] rdData, slvRx;
	wire sclOut, sclOe, sdaOut, sdaOe, irq, dmaTxReq, dmaRxReq, sclPull, sdaPull;
	wire scl = (sclOe ? sclOut : 1'b1) & !sclPull;
	wire sda = (sdaOe ? sdaOut : 1'b1) & !sdaPull;
	int numErrors = 0;
	int comparisons = 0;
	always #20 mclk = ~mclk;
	imc_master u_imc_master (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .altFuncSel(altFuncSel), .sclIn(scl),
		.sdaIn(sda), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq),
		.dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq));
	imc_slave_model u_imc_slave_model (.mclk(mclk), .scl(scl), .sda(sda), .ackEn(ackEn),
		.stretchEn(stretchEn), .txByte(8'hc3), .sdaPull(sdaPull), .sclPull(sclPull),
		.rxByte(slvRx));
	// ==========================================================
	// bus cycles and comparison
	task automatic wr(input [2:0] a, input [7:0] d);
		@(posedge mclk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge mclk);
		wrStb <= 1'b0;
	endtask
	task automatic rd(input [2:0] a, output [7:0] d);
		@(posedge mclk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge mclk);
		rdStb <= 1'b0;
		#1 d = rdData;
	endtask
	task automatic check(input [7:0] got, input [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			numErrors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_bit(input int b, input logic v);
		int i;
		i = 0;
		rd(`IMC_ADDR_STATUS, st);
		while (st[b] !== v && i < 600) begin
			rd(`IMC_ADDR_STATUS, st);
			i++;
		end
		check({7'h00, st[b]}, {7'h00, v});
	endtask
	task automatic settle;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset;
		rd(`IMC_ADDR_STATUS, st);
		check(st, 8'h80);
		rd(`IMC_ADDR_BAUD_HI, st);
		check(st, 8'hff);
		rd(3'h6, st);
		check(st, 8'h00);
		wr(`IMC_ADDR_BAUD_HI, 8'h00);
		wr(`IMC_ADDR_BAUD_LO, 8'h02);
	endtask
	task automatic t_write;
		wr(`IMC_ADDR_CONTROL, 8'h80);
		settle;
		check({7'h00, irq}, 8'h00);
		wr(`IMC_ADDR_CONTROL, 8'h88);
		settle;
		check({6'h00, irq, dmaTxReq}, 8'h03);
		wr(`IMC_ADDR_DATA, 8'ha4);
		rd(`IMC_ADDR_STATUS, st);
		check({7'h00, st[`IMC_ST_TX_EMPTY]}, 8'h00);
		wr(`IMC_ADDR_CONTROL, 8'hc8);
		wait_bit(`IMC_ST_TX_EMPTY, 1'b1);
		repeat (400) @(posedge mclk);
		#1;
		check(slvRx, 8'ha4);
		check({7'h00, sclOe}, 8'h01);
		wr(`IMC_ADDR_DATA, 8'h5a);
		wait_bit(`IMC_ST_TX_EMPTY, 1'b1);
		wr(`IMC_ADDR_CONTROL, 8'ha0);
		wait_bit(`IMC_ST_BUSY, 1'b0);
		check(slvRx, 8'h5a);
		rd(`IMC_ADDR_STATUS, st);
		check({st[`IMC_ST_ACK], st[`IMC_ST_NACK]}, 8'h02);
	endtask
	task automatic t_nack;
		ackEn <= 1'b0;
		wr(`IMC_ADDR_DATA, 8'h90);
		wr(`IMC_ADDR_CONTROL, 8'hc0);
		wait_bit(`IMC_ST_TX_EMPTY, 1'b1);
		wr(`IMC_ADDR_DATA, 8'h11);
		wait_bit(`IMC_ST_NACK, 1'b1);
		check({7'h00, irq}, 8'h01);
		repeat (200) @(posedge mclk);
		rd(`IMC_ADDR_STATUS, st);
		check({st[`IMC_ST_BUSY], st[`IMC_ST_NACK]}, 8'h03);
		wr(`IMC_ADDR_CONTROL, 8'ha2);
		rd(`IMC_ADDR_STATUS, st);
		check({st[`IMC_ST_TX_EMPTY], st[`IMC_ST_NACK]}, 8'h02);
		wait_bit(`IMC_ST_BUSY, 1'b0);
		wr(`IMC_ADDR_DATA, 8'hf0);
		wr(`IMC_ADDR_CONTROL, 8'he0);
		wait_bit(`IMC_ST_BUSY, 1'b0);
		rd(`IMC_ADDR_CONTROL, st);
		check({6'h00, st[`IMC_CTL_START], st[`IMC_CTL_STOP]}, 8'h00);
		rd(`IMC_ADDR_STATUS, st);
		check({4'h0, st[`IMC_ST_ACK], st[`IMC_ST_TEN_BIT], st[`IMC_ST_NACK], irq}, 8'h04);
		ackEn <= 1'b1;
	endtask
	task automatic t_read;
		stretchEn <= 1'b1;
		wr(`IMC_ADDR_DATA, 8'ha5);
		wr(`IMC_ADDR_CONTROL, 8'hc0);
		wait_bit(`IMC_ST_RX_FULL, 1'b1);
		check({6'h00, irq, dmaRxReq}, 8'h03);
		repeat (200) @(posedge mclk);
		rd(`IMC_ADDR_STATUS, st);
		check({st[`IMC_ST_RX_FULL], st[`IMC_ST_READ]}, 8'h03);
		wr(`IMC_ADDR_CONTROL, 8'h84);
		rd(`IMC_ADDR_DATA, st);
		check(st, 8'hc3);
		wait_bit(`IMC_ST_NACK, 1'b1);
		rd(`IMC_ADDR_DATA, st);
		check(st, 8'hc3);
		wr(`IMC_ADDR_CONTROL, 8'ha0);
		wait_bit(`IMC_ST_BUSY, 1'b0);
		rd(`IMC_ADDR_STATUS, st);
		check({st[`IMC_ST_NACK], irq}, 8'h00);
		stretchEn <= 1'b0;
	endtask
	task automatic t_timer;
		@(posedge mclk);
		altFuncSel <= 1'b0;
		wr(`IMC_ADDR_CONTROL, 8'h00);
		wr(`IMC_ADDR_BAUD_LO, 8'h04);
		wr(`IMC_ADDR_CONTROL, 8'h10);
		repeat (10) @(posedge mclk);
		n = 8'h00;
		repeat (40) begin
			@(posedge mclk);
			#1 if (irq === 1'b1) n++;
		end
		check(n, 8'h0a);
		wr(`IMC_ADDR_CONTROL, 8'h00);
		settle;
		check({7'h00, irq}, 8'h00);
	endtask
	// ==========================================================
	// run control
	task end_of_test;
		$display("comparisons %0d errors %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#(40 * 40000);
		numErrors++;
		end_of_test;
	end
	initial begin
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset;
		t_write;
		t_nack;
		t_read;
		t_timer;
		end_of_test;
	end
endmodule // imc_master_tb
bind imc_master imc_master_props u_imc_master_props (.mclk(mclk), .reset_n(reset_n),
	.addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
	.altFuncSel(altFuncSel), .sclIn(sclIn), .sdaIn(sdaIn), .sclOut(sclOut), .sclOe(sclOe),
	.sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq), .dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq));
